// ---- design/io_window_decode.sv ----
// size-aligned io window decoder for one card function
`timescale 1ns/1ps
module io_window_decode (
  input wire logic [15:0] io_addr, // host io address
  input wire logic [15:0] window_base, // programmed base, two implemented bytes
  input wire logic [7:0] window_mask, // io window mask, ones are not decoded
  input wire logic check_disable, // base and limit checking switched off
  output logic window_hit, // address falls inside the window
  output logic [15:0] window_offset // address offset inside the window
);

  logic [15:0] full_mask;
  logic mask_ok;

  // ***********************************************************
  // decode
  // ***********************************************************
  // only the low byte of the mask exists, upper address lines always compare
  assign full_mask = {8'h00, window_mask};
  assign mask_ok = lan_glue_pkg::mask_is_legal(window_mask);

  // base bits under the mask are dropped, so the window is size aligned
  always_comb
  begin
    window_offset = io_addr & full_mask;
    if (check_disable)
    begin
      window_hit = 1'b1;
    end
    else if (window_mask == 8'h00)
    begin
      window_hit = 1'b0;
    end
    else
    begin
      window_hit = mask_ok && (((io_addr ^ window_base) & ~full_mask) == 16'h0000);
    end
  end

endmodule : io_window_decode

// ---- design/lan_glue.sv ----
// network controller glue: io window decode, local bus latch, status and soft reset
`timescale 1ns/1ps
// Behaviour
// - zero mask passes no io cycles unless base and limit checking is off
// - only masks of ones from bit 0 are legal, window 2 to 256 bytes
// - window aligns to its own size; base bits under the mask are ignored
// - mask one excludes its address line, mask zero includes it
// - window base is 16 bits from two bytes; upper base bytes unused
// - network registers respond only while network controller mode is set
// - network mode enables the dma port and data-to-address latch
// - controller raises bus request 0; device answers with bus grant 0
// - address on shared data bus is captured on address strobe
// - controller write strobe drives both sram byte write enables
// - controller interrupt at end of reception is relayed to host logic
// - status register sits at function 0 base plus 0x018 in network mode
// - status bit D6 enables host wait watchdog that raises interrupts
// - watchdog expires after 11.2 us of continuous host wait
// - read-only D3 gives media selection from digital port pin 3
// - write-only D2 drives loopback request on digital port pin 2
// - read-only D1 gives link fail status from digital port pin 1
// - read-only D0 gives media module presence from digital port pin 0
// - network mode fixes port direction and locks attribute access to it
// - reading reset register at base plus 0x01F asserts soft reset 0
module lan_glue (
  input wire logic core_clk, // 200 MHz core clock
  input wire logic resetn, // asynchronous reset, active low
  input wire logic network_controller_mode, // function 0 config option mode bit
  input wire logic check_disable, // base and limit checking off in config option
  input wire logic [15:0] function0_base, // function 0 io base
  input wire logic [7:0] io_window_mask, // function 0 io window mask
  input wire logic soft_reset_polarity_0, // one makes soft reset active low
  input wire logic [3:0] digital_port_direction_select, // attribute direction, non network mode
  input wire logic [3:0] digital_port_value, // attribute port value, non network mode
  input wire logic [15:0] host_addr, // host io address
  input wire logic host_io_rd, // one-cycle host io read request
  input wire logic host_io_wr, // one-cycle host io write request
  input wire logic [7:0] host_wdata, // host io write data
  output logic [7:0] host_rdata, // register read data
  output logic host_rdata_valid, // read data valid pulse
  output logic function0_hit, // address inside function 0 window
  output logic net_reg_hit, // address hits a network register
  input wire logic host_wait_n, // host wait pin, active low
  output logic wait_timeout, // watchdog expiry pulse to interrupt logic
  input wire logic controller_irq, // controller interrupt pin
  output logic host_irq_relay, // controller interrupt towards host logic
  input wire logic bus_request_0, // controller bus request pin
  output logic bus_grant_0, // bus grant to controller
  input wire logic address_strobe, // controller address strobe, active high
  input wire logic [15:0] shared_data_bus, // shared data bus as seen by the latch
  output logic [15:0] latched_address_bus, // sram address held from strobe
  input wire logic controller_mem_write_n, // controller memory write strobe
  output logic sram_write_en_high_n, // sram upper byte write enable
  output logic sram_write_en_low_n, // sram lower byte write enable
  output logic soft_reset_out_0, // controller soft reset, polarity by setting
  input wire logic [3:0] digital_port_pin_in, // digital port pin levels
  output logic [3:0] digital_port_pin_out, // digital port drive values
  output logic [3:0] digital_port_pin_oe, // digital port drive enables
  output logic [3:0] digital_port_direction, // effective port direction
  output logic digital_port_attr_lock // blocks attribute access to the direction
);

  // ***********************************************************
  // state
  // ***********************************************************
  typedef struct packed {
    logic [1:0] wait_sync;
    logic [1:0] irq_sync;
    logic [1:0] req_sync;
    logic [2:0] ads_sync;
    logic [15:0] data_sync1;
    logic [15:0] data_sync2;
    logic [1:0] wr_sync;
    logic [3:0] port_sync1;
    logic [3:0] port_sync2;
    logic [7:0] rdata;
    logic rdata_valid;
    logic watchdog_en;
    logic loopback;
    logic [lan_glue_pkg::WAIT_COUNT_W-1:0] wait_count;
    logic wait_expired;
    logic wait_timeout;
    logic irq_relay;
    logic grant;
    logic [15:0] latched_addr;
    logic sram_we_n;
    lan_glue_pkg::soft_reset_state_e srst_state;
    logic [lan_glue_pkg::SRST_COUNT_W-1:0] srst_count;
  } lan_state_s;

  lan_state_s state_q;
  lan_state_s state_d;
  logic [15:0] window_offset;
  logic window_hit;
  logic status_sel;
  logic reset_sel;

  // ***********************************************************
  // io window decode
  // ***********************************************************
  io_window_decode u_window (
    .io_addr(host_addr),
    .window_base(function0_base),
    .window_mask(io_window_mask),
    .check_disable(check_disable),
    .window_hit(window_hit),
    .window_offset(window_offset)
  );

  // network registers only exist in network mode
  assign status_sel = network_controller_mode && window_hit &&
    (window_offset == lan_glue_pkg::NET_STATUS_OFFSET);
  assign reset_sel = network_controller_mode && window_hit &&
    (window_offset == lan_glue_pkg::SOFT_RESET_OFFSET);

  // ***********************************************************
  // next state
  // ***********************************************************
  always_comb
  begin
    state_d = state_q;

    // pins pass two flops before anything reads them
    state_d.wait_sync = {state_q.wait_sync[0], host_wait_n};
    state_d.irq_sync = {state_q.irq_sync[0], controller_irq};
    state_d.req_sync = {state_q.req_sync[0], bus_request_0};
    state_d.ads_sync = {state_q.ads_sync[1:0], address_strobe};
    state_d.data_sync1 = shared_data_bus;
    state_d.data_sync2 = state_q.data_sync1;
    state_d.wr_sync = {state_q.wr_sync[0], controller_mem_write_n};
    state_d.port_sync1 = digital_port_pin_in;
    state_d.port_sync2 = state_q.port_sync1;

    // register reads answer one cycle after the request
    state_d.rdata_valid = host_io_rd && (status_sel || reset_sel);
    state_d.rdata = lan_glue_pkg::RDATA_RESET;
    if (host_io_rd && status_sel)
    begin
      // loopback is write only and reads back as zero
      state_d.rdata[lan_glue_pkg::WATCHDOG_EN_BIT] = state_q.watchdog_en;
      state_d.rdata[lan_glue_pkg::MEDIA_SELECT_BIT] =
        state_q.port_sync2[lan_glue_pkg::MEDIA_SELECT_PIN];
      state_d.rdata[lan_glue_pkg::LINK_FAIL_BIT] =
        state_q.port_sync2[lan_glue_pkg::LINK_FAIL_PIN];
      state_d.rdata[lan_glue_pkg::MEDIA_MODULE_BIT] =
        state_q.port_sync2[lan_glue_pkg::MEDIA_MODULE_PIN];
    end

    // status writes steer the watchdog and the loopback line
    if (host_io_wr && status_sel)
    begin
      state_d.watchdog_en = host_wdata[lan_glue_pkg::WATCHDOG_EN_BIT];
      state_d.loopback = host_wdata[lan_glue_pkg::LOOPBACK_BIT];
    end

    // watchdog counts continuous wait; one pulse per stretch of wait
    if (state_q.watchdog_en && !state_q.wait_sync[1])
    begin
      if (state_q.wait_count != lan_glue_pkg::WAIT_TIMEOUT_COUNT)
      begin
        state_d.wait_count = state_q.wait_count + 1'b1;
      end
    end
    else
    begin
      state_d.wait_count = '0;
    end
    state_d.wait_timeout = (state_q.wait_count == lan_glue_pkg::WAIT_TIMEOUT_COUNT) &&
      !state_q.wait_expired;
    state_d.wait_expired = (state_q.wait_count == lan_glue_pkg::WAIT_TIMEOUT_COUNT);

    // controller interrupt is passed on as a level
    state_d.irq_relay = network_controller_mode && state_q.irq_sync[1];

    // the local bus is free for the controller whenever it asks in network mode
    state_d.grant = network_controller_mode && state_q.req_sync[1];

    // capture the address on the strobe's rising edge and hold it after
    if (network_controller_mode && state_q.ads_sync[1] && !state_q.ads_sync[2])
    begin
      state_d.latched_addr = state_q.data_sync2;
    end

    // both byte lanes are written while the controller's strobe is low
    state_d.sram_we_n = !(network_controller_mode && state_q.grant && !state_q.wr_sync[1]);

    // a read of the reset register starts a fixed-length soft reset
    unique case (state_q.srst_state)
      lan_glue_pkg::SRST_IDLE:
      begin
        state_d.srst_count = '0;
        if (host_io_rd && reset_sel)
        begin
          state_d.srst_state = lan_glue_pkg::SRST_ACTIVE;
        end
      end
      lan_glue_pkg::SRST_ACTIVE:
      begin
        state_d.srst_count = state_q.srst_count + 1'b1;
        if (state_q.srst_count == lan_glue_pkg::SOFT_RESET_COUNT - 1'b1)
        begin
          state_d.srst_state = lan_glue_pkg::SRST_IDLE;
        end
      end
      default:
      begin
        state_d.srst_state = lan_glue_pkg::SRST_IDLE;
      end
    endcase
  end

  // ***********************************************************
  // state register
  // ***********************************************************
  always_ff @(posedge core_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      state_q <= '0;
      state_q.wait_sync <= 2'h3;
      state_q.ads_sync <= 3'h0;
      state_q.wr_sync <= 2'h3;
      state_q.rdata <= lan_glue_pkg::RDATA_RESET;
      state_q.watchdog_en <= lan_glue_pkg::WATCHDOG_EN_RESET;
      state_q.loopback <= lan_glue_pkg::LOOPBACK_RESET;
      state_q.latched_addr <= lan_glue_pkg::LATCHED_ADDR_RESET;
      state_q.sram_we_n <= 1'b1;
      state_q.srst_state <= lan_glue_pkg::SRST_IDLE;
    end
    else
    begin
      state_q <= state_d;
    end
  end

  // ***********************************************************
  // outputs
  // ***********************************************************
  assign host_rdata = state_q.rdata;
  assign host_rdata_valid = state_q.rdata_valid;
  assign function0_hit = window_hit;
  assign net_reg_hit = status_sel || reset_sel;
  assign wait_timeout = state_q.wait_timeout;
  assign host_irq_relay = state_q.irq_relay;
  assign bus_grant_0 = state_q.grant;
  assign latched_address_bus = state_q.latched_addr;
  assign sram_write_en_high_n = state_q.sram_we_n;
  assign sram_write_en_low_n = state_q.sram_we_n;

  // polarity one gives an active low pulse, as the controller expects
  assign soft_reset_out_0 = (state_q.srst_state == lan_glue_pkg::SRST_ACTIVE) ^
    soft_reset_polarity_0;

  // network mode pins the port direction and hides it from attribute space
  always_comb
  begin
    if (network_controller_mode)
    begin
      digital_port_direction = lan_glue_pkg::NET_PORT_DIRECTION;
      digital_port_pin_out = 4'h0;
      digital_port_pin_out[lan_glue_pkg::LOOPBACK_PIN] = state_q.loopback;
    end
    else
    begin
      digital_port_direction = digital_port_direction_select;
      digital_port_pin_out = digital_port_value;
    end
    digital_port_pin_oe = digital_port_direction;
  end
  assign digital_port_attr_lock = network_controller_mode;

endmodule : lan_glue

// ---- design/lan_glue_pkg.sv ----
// constants, types and register map of the network glue block
package lan_glue_pkg;

  // ***********************************************************
  // register offsets inside the function 0 io window
  // ***********************************************************
  localparam logic [15:0] NET_STATUS_OFFSET = 16'h0018;
  localparam logic [15:0] SOFT_RESET_OFFSET = 16'h001f;

  // ***********************************************************
  // network status register field positions
  // ***********************************************************
  localparam int WATCHDOG_EN_BIT = 6;
  localparam int MEDIA_SELECT_BIT = 3;
  localparam int LOOPBACK_BIT = 2;
  localparam int LINK_FAIL_BIT = 1;
  localparam int MEDIA_MODULE_BIT = 0;

  // ***********************************************************
  // digital port lines and their fixed direction in network mode
  // ***********************************************************
  localparam int MEDIA_SELECT_PIN = 3;
  localparam int LOOPBACK_PIN = 2;
  localparam int LINK_FAIL_PIN = 1;
  localparam int MEDIA_MODULE_PIN = 0;
  localparam logic [3:0] NET_PORT_DIRECTION = 4'h4;

  // ***********************************************************
  // values after reset
  // ***********************************************************
  localparam logic [7:0] RDATA_RESET = 8'h00;
  localparam logic [15:0] LATCHED_ADDR_RESET = 16'h0000;
  localparam logic WATCHDOG_EN_RESET = 1'b0;
  localparam logic LOOPBACK_RESET = 1'b0;

  // ***********************************************************
  // timing
  // ***********************************************************
  localparam int CORE_CLK_PERIOD_PS = 5000;
  localparam int WAIT_TIMEOUT_PS = 11200000;
  // longest wait, so the count rounds down
  localparam int WAIT_TIMEOUT_CYCLES = WAIT_TIMEOUT_PS / CORE_CLK_PERIOD_PS;
  localparam int WAIT_COUNT_W = 12;
  localparam logic [WAIT_COUNT_W-1:0] WAIT_TIMEOUT_COUNT = WAIT_TIMEOUT_CYCLES[WAIT_COUNT_W-1:0];
  localparam int SOFT_RESET_CYCLES = 16;
  localparam int SRST_COUNT_W = 5;
  localparam logic [SRST_COUNT_W-1:0] SOFT_RESET_COUNT = SOFT_RESET_CYCLES[SRST_COUNT_W-1:0];

  // ***********************************************************
  // soft reset sequencer states
  // ***********************************************************
  typedef enum logic [1:0] {
    SRST_IDLE = 2'b00,
    SRST_ACTIVE = 2'b01
  } soft_reset_state_e;

  // legal window masks are ones packed from bit 0 upward
  function automatic logic mask_is_legal(input logic [7:0] mask);
    return ((mask & (mask + 8'h01)) == 8'h00);
  endfunction : mask_is_legal

endpackage : lan_glue_pkg

// ---- testbench/lan_ctl_model.sv ----
// network controller and buffer sram model facing the glue block
`timescale 1ns/1ps
module lan_ctl_model (
  input wire logic core_clk, // clock
  input wire logic bus_grant_0, // grant
  input wire logic [15:0] latched_address_bus, // sram address
  input wire logic sram_write_en_low_n, // sram write
  output logic bus_request_0, // request
  output logic address_strobe, // strobe
  output logic [15:0] shared_data_bus, // address, then data
  output logic controller_mem_write_n, // write strobe
  output logic controller_irq // reception done
);
  logic [15:0] mem [16];
  // ****
  // idle levels
  // ****
  initial
  begin
    bus_request_0 = 1'b0;
    address_strobe = 1'b0;
    shared_data_bus = 16'h0000;
    controller_mem_write_n = 1'b1;
    controller_irq = 1'b0;
  end
  // sram sees the raw bus, so data must outlast the enables
  always @(posedge core_clk)
    if (sram_write_en_low_n === 1'b0)
      mem[latched_address_bus[3:0]] <= shared_data_bus;
  // one receive burst; gap slows the controller down
  task automatic dma_write(input logic [15:0] addr, input logic [15:0] data, input int gap);
    int n;
    n = 0;
    @(posedge core_clk);
    controller_irq <= 1'b0;
    bus_request_0 <= 1'b1;
    while (bus_grant_0 !== 1'b1 && n < 20)
    begin
      @(posedge core_clk);
      n++;
    end
    shared_data_bus <= addr;
    repeat (gap + 2) @(posedge core_clk);
    address_strobe <= 1'b1;
    repeat (2) @(posedge core_clk);
    address_strobe <= 1'b0;
    repeat (4) @(posedge core_clk);
    shared_data_bus <= data;
    controller_mem_write_n <= 1'b0;
    repeat (gap + 4) @(posedge core_clk);
    controller_mem_write_n <= 1'b1;
    repeat (5) @(posedge core_clk);
    bus_request_0 <= 1'b0;
    shared_data_bus <= ~data; // a released bus must not look held
    controller_irq <= 1'b1;
  endtask : dma_write
endmodule : lan_ctl_model

// ---- testbench/lan_glue_assertions.sv ----
// port checker for the network glue block
`timescale 1ns/1ps
module lan_glue_assertions (
  input wire logic core_clk, // clock
  input wire logic resetn, // reset, low
  input wire logic network_controller_mode, // mode
  input wire logic [7:0] io_window_mask, // mask
  input wire logic soft_reset_polarity_0, // polarity
  input wire logic [15:0] host_addr, // io address
  input wire logic host_io_rd, // read
  input wire logic [7:0] host_rdata, // read data
  input wire logic host_rdata_valid, // read valid
  input wire logic net_reg_hit, // register hit
  input wire logic host_wait_n, // host wait
  input wire logic wait_timeout, // expiry
  input wire logic bus_request_0, // request
  input wire logic bus_grant_0, // grant
  input wire logic address_strobe, // strobe
  input wire logic [15:0] shared_data_bus, // bus
  input wire logic [15:0] latched_address_bus, // address
  input wire logic controller_mem_write_n, // write
  input wire logic sram_write_en_high_n, // we high
  input wire logic sram_write_en_low_n, // we low
  input wire logic soft_reset_out_0, // soft reset
  input wire logic [3:0] digital_port_pin_oe, // enables
  input wire logic [3:0] digital_port_direction, // direction
  input wire logic digital_port_attr_lock // lock
);
  default clocking @(posedge core_clk);
  endclocking
  default disable iff (!resetn);
  // ****
  // host wait run length
  // ****
  logic [11:0] wait_run_q;
  logic [11:0] wait_run_d;
  // saturates so a very long wait never wraps under the limit
  always_comb
    wait_run_d = host_wait_n ? 12'h000 : wait_run_q + {11'h000, wait_run_q != 12'hfff};
  always_ff @(posedge core_clk or negedge resetn)
    if (!resetn)
      wait_run_q <= 12'h000;
    else
      wait_run_q <= wait_run_d;
  // ****
  // sequences and checks
  // ****
  sequence req_held;
    bus_request_0 [*3];
  endsequence
  sequence write_held;
    (!controller_mem_write_n && bus_grant_0 && network_controller_mode) [*4];
  endsequence
  sequence srst_active;
    (soft_reset_out_0 != soft_reset_polarity_0) [*8];
  endsequence
  a_grant_on_req: assert property (req_held |=> bus_grant_0) else $error("grant late");
  a_latch_take:
    assert property ($rose(address_strobe) |-> ##4 latched_address_bus == $past(shared_data_bus, 4))
    else $error("latched address wrong");
  a_latch_hold:
    assert property ($changed(latched_address_bus) |-> $past(address_strobe, 3) && !$past(address_strobe, 4))
    else $error("latched address moved");
  a_we_pair: assert property (sram_write_en_high_n == sram_write_en_low_n) else $error("we split");
  a_we_low: assert property (write_held |=> !sram_write_en_low_n) else $error("we missing");
  a_read_answer:
    assert property (host_rdata_valid == $past(host_io_rd && net_reg_hit)) else $error("read answer wrong");
  a_reg_mode: assert property (net_reg_hit |-> network_controller_mode) else $error("hit outside mode");
  a_soft_reset:
    assert property (host_io_rd && net_reg_hit && (host_addr & {8'h00, io_window_mask}) ==
      lan_glue_pkg::SOFT_RESET_OFFSET |=> srst_active) else $error("soft reset short");
  a_port_dir:
    assert property (network_controller_mode |-> digital_port_direction == lan_glue_pkg::NET_PORT_DIRECTION
      && digital_port_pin_oe == digital_port_direction && digital_port_attr_lock) else $error("port direction");
  a_wait_limit: assert property (wait_timeout |-> wait_run_q >= 12'h8c0) else $error("early expiry");
endmodule : lan_glue_assertions

// ---- testbench/lan_glue_bench.sv ----
// self-checking bench for the network glue block
`timescale 1ns/1ps
`define CHK(n, e, g) begin num_checks++; if ((g) !== (e)) \
  begin mismatches++; $display("wrong value %s expected %h seen %h", n, e, g); end end
module lan_glue_bench;
  logic core_clk, resetn, network_controller_mode, check_disable, soft_reset_polarity_0;
  logic host_io_rd, host_io_wr, host_rdata_valid, function0_hit, net_reg_hit, host_wait_n, wait_timeout;
  logic controller_irq, host_irq_relay, bus_request_0, bus_grant_0, address_strobe, controller_mem_write_n;
  logic sram_write_en_high_n, sram_write_en_low_n, soft_reset_out_0, digital_port_attr_lock;
  logic [15:0] function0_base, host_addr, shared_data_bus, latched_address_bus;
  logic [7:0] io_window_mask, host_wdata, host_rdata, exp_v;
  logic [3:0] digital_port_direction_select, digital_port_value, digital_port_pin_in;
  logic [3:0] digital_port_pin_out, digital_port_pin_oe, digital_port_direction;
  logic [7:0] exp_q[$];
  logic [7:0] masks [10] = '{8'h00, 8'h01, 8'h03, 8'h07, 8'h0f, 8'h1f, 8'h3f, 8'h7f, 8'hff, 8'h09};
  int mismatches, num_checks, seed;
  lan_glue i_dut (.core_clk, .resetn, .network_controller_mode, .check_disable, .function0_base,
    .io_window_mask, .soft_reset_polarity_0, .digital_port_direction_select, .digital_port_value,
    .host_addr, .host_io_rd, .host_io_wr, .host_wdata, .host_rdata, .host_rdata_valid, .function0_hit,
    .net_reg_hit, .host_wait_n, .wait_timeout, .controller_irq, .host_irq_relay, .bus_request_0,
    .bus_grant_0, .address_strobe, .shared_data_bus, .latched_address_bus, .controller_mem_write_n,
    .sram_write_en_high_n, .sram_write_en_low_n, .soft_reset_out_0, .digital_port_pin_in,
    .digital_port_pin_out, .digital_port_pin_oe, .digital_port_direction, .digital_port_attr_lock);
  lan_ctl_model i_ctl (.core_clk, .bus_grant_0, .latched_address_bus, .sram_write_en_low_n, .bus_request_0,
    .address_strobe, .shared_data_bus, .controller_mem_write_n, .controller_irq);
  // ****
  // clock, answer monitor and tasks
  // ****
  initial
  begin
    core_clk = 1'b0;
    forever #2.5 core_clk = ~core_clk;
  end
  // an answer with nothing noted is caught as an unknown expectation
  always @(negedge core_clk)
    if (host_rdata_valid === 1'b1)
    begin
      exp_v = exp_q.size() > 0 ? exp_q.pop_front() : 8'hxx;
      `CHK("host_rdata", exp_v, host_rdata)
    end
  task automatic io(input logic rd, input logic [7:0] off, input logic [7:0] wd);
    @(posedge core_clk);
    host_addr <= function0_base + {8'h00, off};
    host_io_rd <= rd;
    host_io_wr <= ~rd;
    host_wdata <= wd;
    @(posedge core_clk);
    host_io_rd <= 1'b0;
    host_io_wr <= 1'b0;
  endtask : io
  task automatic summarize();
    if (mismatches == 0 && num_checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : summarize
  // hang guard, far beyond the few thousand cycles the run needs
  initial
  begin
    repeat (20000) @(posedge core_clk);
    mismatches++;
    summarize();
  end
  // ****
  // main sequence
  // ****
  initial
  begin
    logic [15:0] a, b;
    logic [7:0] m;
    logic [3:0] pins;
    logic exp_hit;
    int n;
    resetn = 1'b0;
    network_controller_mode = 1'b1;
    check_disable = 1'b0;
    soft_reset_polarity_0 = 1'b1;
    function0_base = 16'h0000;
    io_window_mask = 8'h00;
    digital_port_direction_select = 4'h0;
    digital_port_value = 4'h0;
    digital_port_pin_in = 4'h0;
    host_addr = 16'h0000;
    host_io_rd = 1'b0;
    host_io_wr = 1'b0;
    host_wdata = 8'h00;
    host_wait_n = 1'b1;
    mismatches = 0;
    num_checks = 0;
    seed = 13;
    repeat (20) @(posedge core_clk);
    resetn <= 1'b1;
    // window sweep over the zero mask, every legal mask and illegal 0x09, aligned and unaligned bases
    for (int i = 0; i < 60; i++)
    begin
      b = i == 0 ? 16'h0374 : 16'($random(seed));
      m = i == 0 ? 8'h07 : masks[i % 10];
      a = i == 0 ? 16'h0370 : b ^ (16'($random(seed)) & 16'h01ff);
      @(posedge core_clk);
      function0_base <= b;
      io_window_mask <= m;
      host_addr <= a;
      check_disable <= i % 7 == 6;
      @(negedge core_clk);
      exp_hit = (i % 7 == 6) | (m != 8'h00 && (m & (m + 8'h01)) == 8'h00 && ((a ^ b) & ~{8'h00, m}) == 16'h0000);
      `CHK("function0_hit", exp_hit, function0_hit)
    end
    @(posedge core_clk);
    function0_base <= 16'h0300;
    io_window_mask <= 8'h1f;
    check_disable <= 1'b0;
    pins = 4'($random(seed));
    digital_port_pin_in <= pins;
    repeat (4) @(posedge core_clk);
    `CHK("port direction", 4'h4, digital_port_direction)
    for (int k = 0; k < 2; k++)
    begin
      io(1'b0, 8'h18, k == 0 ? 8'hff : 8'h00);
      @(negedge core_clk);
      `CHK("loopback pin", k == 0, digital_port_pin_out[2])
      exp_q.push_back({1'b0, k == 0, 2'b00, pins[3], 1'b0, pins[1:0]});
      io(1'b1, 8'h18, 8'h00);
    end
    exp_q.push_back(8'h00);
    io(1'b1, 8'h1f, 8'h00);
    repeat (2) @(negedge core_clk);
    `CHK("soft reset active", 1'b0, soft_reset_out_0)
    repeat (20) @(negedge core_clk);
    `CHK("soft reset idle", 1'b1, soft_reset_out_0)
    // outside network mode nothing answers and the enable write is lost
    @(posedge core_clk);
    network_controller_mode <= 1'b0;
    digital_port_direction_select <= 4'h9;
    io(1'b1, 8'h18, 8'h00);
    io(1'b1, 8'h1f, 8'h00);
    io(1'b0, 8'h18, 8'h40);
    repeat (2) @(negedge core_clk);
    `CHK("direction outside mode", 4'h9, digital_port_direction)
    `CHK("no soft reset", 1'b1, soft_reset_out_0)
    @(posedge core_clk);
    network_controller_mode <= 1'b1;
    for (int k = 0; k < 2; k++)
    begin
      a = 16'($random(seed));
      b = 16'($random(seed));
      i_ctl.dma_write(a, b, k * 5 + 1);
      @(negedge core_clk);
      `CHK("latched address", a, latched_address_bus)
      `CHK("sram word", b, i_ctl.mem[a[3:0]])
      repeat (4) @(negedge core_clk);
      `CHK("irq relay", 1'b1, host_irq_relay)
    end
    // long host wait, first with the watchdog off, then on
    for (int k = 0; k < 2; k++)
    begin
      if (k == 1)
        io(1'b0, 8'h18, 8'h40);
      @(posedge core_clk);
      host_wait_n <= 1'b0;
      n = 0;
      repeat (2300)
      begin
        @(negedge core_clk);
        if (wait_timeout === 1'b1)
          n++;
      end
      @(posedge core_clk);
      host_wait_n <= 1'b1;
      `CHK("timeout pulses", k, n)
    end
    `CHK("pending reads", 0, exp_q.size())
    summarize();
  end
endmodule : lan_glue_bench
bind lan_glue lan_glue_assertions i_chk (.core_clk, .resetn, .network_controller_mode, .io_window_mask,
  .soft_reset_polarity_0, .host_addr, .host_io_rd, .host_rdata, .host_rdata_valid, .net_reg_hit,
  .host_wait_n, .wait_timeout, .bus_request_0, .bus_grant_0, .address_strobe, .shared_data_bus,
  .latched_address_bus, .controller_mem_write_n, .sram_write_en_high_n, .sram_write_en_low_n,
  .soft_reset_out_0, .digital_port_pin_oe, .digital_port_direction, .digital_port_attr_lock);
